// [verilog/aao_top.sv]
/*
 Execution datapath for the add, AND, complement, decrement, decimal
 adjust, clear, call and watchdog clear operations of an 8-bit core,
 with an APB slave for accumulator, status and watchdog inspection.
 Assumes the decoder presents one operation per op_valid pulse with the
 addressed byte already read onto mem_rdata, all on pclk.
*/
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module aao_top #(
   parameter int WDT_WIDTH  = 8,
   parameter int ADDR_WIDTH = 8,
   parameter int PC_WIDTH   = 12
) (
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Operation request from decoder
   input  wire logic                   op_valid,
   input  wire logic [4:0]             op_code,
   input  wire logic [ADDR_WIDTH-1:0]  mem_addr,
   input  wire logic [7:0]             mem_rdata,
   input  wire logic [7:0]             imm_data,
   input  wire logic [2:0]             bit_sel,
   input  wire logic [PC_WIDTH-1:0]    pc_now,
   input  wire logic [PC_WIDTH-1:0]    call_target,
   input  wire logic                   power_down_set,
   // Data memory write
   output logic                        mem_we,
   output logic      [ADDR_WIDTH-1:0]  mem_waddr,
   output logic      [7:0]             mem_wdata,
   // Sequencer
   output logic                        stack_push,
   output logic      [PC_WIDTH-1:0]    stack_data,
   output logic                        pc_load,
   output logic      [PC_WIDTH-1:0]    pc_target,
   // Core state
   output logic      [7:0]             accumulator_reg,
   output logic                        carry_flag,
   output logic                        aux_carry_flag,
   output logic                        zero_flag,
   output logic                        overflow_flag,
   output logic                        power_down_flag,
   output logic                        timeout_flag,
   output logic      [WDT_WIDTH-1:0]   watchdog_count
);

   if (WDT_WIDTH < 2 || WDT_WIDTH > 32) begin : g_wdt_check
      $error("WDT_WIDTH must lie between 2 and 32");
   end
   if (PC_WIDTH < 1 || PC_WIDTH > 32 || ADDR_WIDTH < 1) begin : g_w_check
      $error("PC_WIDTH or ADDR_WIDTH out of range");
   end

   // Sum with flags: {ov, ac, c, sum}
   function automatic logic [10:0] add8(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       cin);
      logic [4:0] low;
      logic [8:0] full;
      logic       ov;
      low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      ov   = (a[7] == b[7]) && (full[7] != a[7]);
      return {ov, low[4], full[8], full[7:0]};
   endfunction

   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   logic [10:0]          add_mem;
   logic [10:0]          add_mem_c;
   logic [10:0]          add_imm;
   logic [4:0]           low_sum;
   logic [4:0]           high_sum;
   logic                 nibble_adjust_carry;
   logic [7:0]           next_acc;
   logic                 next_c;
   logic                 next_ac;
   logic                 next_z;
   logic                 next_ov;
   logic                 next_mem_we;
   logic [7:0]           next_mem_wdata;
   logic                 next_push;
   logic                 wdt_clear;
   logic                 next_first;
   logic                 next_second;
   logic                 preclear_first;
   logic                 preclear_second;
   logic                 apb_access;
   logic                 apb_write;
   logic                 addr_ok;
   logic [7:0]           status_bits;
   logic                 wdt_wrap;
   aao_pkg::aao_op_type  op;

   assign op      = aao_pkg::aao_op_type'(op_code);
   assign add_mem   = add8(accumulator_reg, mem_rdata, 1'b0);
   assign add_mem_c = add8(accumulator_reg, mem_rdata, carry_flag);
   assign add_imm   = add8(accumulator_reg, imm_data, 1'b0);

   assign apb_access = psel && penable && !pready;
   assign apb_write  = apb_access && pwrite && addr_ok;
   assign addr_ok    = (paddr == aao_pkg::ACC_OFFSET)
                    || (paddr == aao_pkg::STATUS_OFFSET)
                    || (paddr == aao_pkg::WDT_OFFSET)
                    || (paddr == aao_pkg::PRECLR_OFFSET);
   assign wdt_wrap   = &watchdog_count;

   always_comb begin
      status_bits = 8'h00;
      status_bits[aao_pkg::C_BIT]   = carry_flag;
      status_bits[aao_pkg::AC_BIT]  = aux_carry_flag;
      status_bits[aao_pkg::Z_BIT]   = zero_flag;
      status_bits[aao_pkg::OV_BIT]  = overflow_flag;
      status_bits[aao_pkg::PDF_BIT] = power_down_flag;
      status_bits[aao_pkg::TO_BIT]  = timeout_flag;
   end

   // Decimal adjust nibble arithmetic
   always_comb begin
      if (accumulator_reg[3:0] > aao_pkg::BCD_LIMIT[3:0] ||
          aux_carry_flag) begin
         low_sum = {1'b0, accumulator_reg[3:0]} + aao_pkg::BCD_ADJUST;
      end else begin
         low_sum = {1'b0, accumulator_reg[3:0]};
      end
      nibble_adjust_carry = low_sum[4];
      high_sum = {1'b0, accumulator_reg[7:4]}
               + {4'h0, nibble_adjust_carry};
      if (high_sum > aao_pkg::BCD_LIMIT || carry_flag) begin
         high_sum = high_sum + aao_pkg::BCD_ADJUST;
      end
   end

   // Operation decode: next values of accumulator, flags and memory
   always_comb begin
      next_acc       = accumulator_reg;
      next_c         = carry_flag;
      next_ac        = aux_carry_flag;
      next_z         = zero_flag;
      next_ov        = overflow_flag;
      next_mem_we    = 1'b0;
      next_mem_wdata = mem_rdata;
      next_push      = 1'b0;
      wdt_clear      = 1'b0;
      next_first     = preclear_first;
      next_second    = preclear_second;
      if (op_valid) begin
         unique case (op)
            aao_pkg::OP_ADC_ACC: begin
               next_acc = add_mem_c[7:0];
               {next_ac, next_c} = add_mem_c[9:8];
               next_z   = is_zero(add_mem_c[7:0]);
            end
            aao_pkg::OP_ADC_MEM: begin
               next_mem_we    = 1'b1;
               next_mem_wdata = add_mem_c[7:0];
               {next_ov, next_ac, next_c} = add_mem_c[10:8];
               next_z         = is_zero(add_mem_c[7:0]);
            end
            aao_pkg::OP_ADD_ACC: begin
               next_acc = add_mem[7:0];
               {next_ov, next_ac, next_c} = add_mem[10:8];
               next_z   = is_zero(add_mem[7:0]);
            end
            aao_pkg::OP_ADD_IMM: begin
               next_acc = add_imm[7:0];
               {next_ov, next_ac, next_c} = add_imm[10:8];
               next_z   = is_zero(add_imm[7:0]);
            end
            aao_pkg::OP_ADD_MEM: begin
               next_mem_we    = 1'b1;
               next_mem_wdata = add_mem[7:0];
               {next_ov, next_ac, next_c} = add_mem[10:8];
               next_z         = is_zero(add_mem[7:0]);
            end
            aao_pkg::OP_AND_ACC: begin
               next_acc = accumulator_reg & mem_rdata;
               next_z   = is_zero(accumulator_reg & mem_rdata);
            end
            aao_pkg::OP_AND_IMM: begin
               next_acc = accumulator_reg & imm_data;
               next_z   = is_zero(accumulator_reg & imm_data);
            end
            aao_pkg::OP_AND_MEM: begin
               next_mem_we    = 1'b1;
               next_mem_wdata = accumulator_reg & mem_rdata;
               next_z         = is_zero(accumulator_reg & mem_rdata);
            end
            aao_pkg::OP_CALL: begin
               next_push = 1'b1;
            end
            aao_pkg::OP_CLEAR_BYTE: begin
               next_mem_we    = 1'b1;
               next_mem_wdata = 8'h00;
            end
            aao_pkg::OP_CLEAR_BIT: begin
               next_mem_we             = 1'b1;
               next_mem_wdata[bit_sel] = 1'b0;
            end
            aao_pkg::OP_WDT_SINGLE: begin
               wdt_clear = 1'b1;
            end
            aao_pkg::OP_WDT_FIRST: begin
               // Pair completes only with the other half pending
               if (preclear_second) begin
                  wdt_clear   = 1'b1;
                  next_second = 1'b0;
               end else begin
                  next_first = 1'b1;
               end
            end
            aao_pkg::OP_WDT_SECOND: begin
               if (preclear_first) begin
                  wdt_clear  = 1'b1;
                  next_first = 1'b0;
               end else begin
                  next_second = 1'b1;
               end
            end
            aao_pkg::OP_INVERT_MEM: begin
               next_mem_we    = 1'b1;
               next_mem_wdata = ~mem_rdata;
               next_z         = is_zero(~mem_rdata);
            end
            aao_pkg::OP_INVERT_ACC: begin
               next_acc = ~mem_rdata;
               next_z   = is_zero(~mem_rdata);
            end
            aao_pkg::OP_DEC_ADJUST: begin
               next_mem_we    = 1'b1;
               next_mem_wdata = {high_sum[3:0], low_sum[3:0]};
               if (high_sum > aao_pkg::BCD_LIMIT || carry_flag) begin
                  next_c = 1'b1;
               end
            end
            aao_pkg::OP_DEC_MEM: begin
               next_mem_we    = 1'b1;
               next_mem_wdata = mem_rdata - 8'h01;
               next_z         = is_zero(mem_rdata - 8'h01);
            end
            aao_pkg::OP_DEC_ACC: begin
               next_acc = mem_rdata - 8'h01;
               next_z   = is_zero(mem_rdata - 8'h01);
            end
            default: begin
               next_acc = accumulator_reg;
            end
         endcase
      end
   end

   // Accumulator: an operation outranks a software write in that cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accumulator_reg <= aao_pkg::ACC_RESET;
      end else if (op_valid) begin
         accumulator_reg <= next_acc;
      end else if (apb_write && paddr == aao_pkg::ACC_OFFSET) begin
         accumulator_reg <= pwdata[7:0];
      end
   end

   // Arithmetic flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carry_flag     <= aao_pkg::FLAG_RESET;
         aux_carry_flag <= aao_pkg::FLAG_RESET;
         zero_flag      <= aao_pkg::FLAG_RESET;
         overflow_flag  <= aao_pkg::FLAG_RESET;
      end else if (op_valid) begin
         carry_flag     <= next_c;
         aux_carry_flag <= next_ac;
         zero_flag      <= next_z;
         overflow_flag  <= next_ov;
      end else if (apb_write && paddr == aao_pkg::STATUS_OFFSET) begin
         carry_flag     <= pwdata[aao_pkg::C_BIT];
         aux_carry_flag <= pwdata[aao_pkg::AC_BIT];
         zero_flag      <= pwdata[aao_pkg::Z_BIT];
         overflow_flag  <= pwdata[aao_pkg::OV_BIT];
      end
   end

   // Watchdog counter and its flags; a set wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_count  <= '0;
         timeout_flag    <= aao_pkg::FLAG_RESET;
         power_down_flag <= aao_pkg::FLAG_RESET;
      end else begin
         if (wdt_clear) begin
            watchdog_count <= '0;
         end else begin
            watchdog_count <= watchdog_count + 1'b1;
         end
         if (wdt_wrap) begin
            timeout_flag <= 1'b1;
         end else if (wdt_clear) begin
            timeout_flag <= 1'b0;
         end
         if (power_down_set) begin
            power_down_flag <= 1'b1;
         end else if (wdt_clear) begin
            power_down_flag <= 1'b0;
         end
      end
   end

   // Pre-clear indicators
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preclear_first  <= 1'b0;
         preclear_second <= 1'b0;
      end else begin
         preclear_first  <= next_first;
         preclear_second <= next_second;
      end
   end

   // Memory write and sequencer outputs, one cycle after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_we     <= 1'b0;
         mem_waddr  <= '0;
         mem_wdata  <= 8'h00;
         stack_push <= 1'b0;
         stack_data <= '0;
         pc_load    <= 1'b0;
         pc_target  <= '0;
      end else begin
         mem_we     <= next_mem_we;
         mem_waddr  <= mem_addr;
         mem_wdata  <= next_mem_wdata;
         stack_push <= next_push;
         stack_data <= pc_now + 1'b1;
         pc_load    <= next_push;
         pc_target  <= call_target;
      end
   end

   // APB answer after one wait cycle; unmapped offsets raise pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apb_access;
         pslverr <= apb_access && !addr_ok;
         prdata  <= 32'h0000_0000;
         if (apb_access && !pwrite) begin
            unique case (paddr)
               aao_pkg::ACC_OFFSET:
                  prdata <= {24'h00_0000, accumulator_reg};
               aao_pkg::STATUS_OFFSET:
                  prdata <= {24'h00_0000, status_bits};
               aao_pkg::WDT_OFFSET:
                  prdata <= 32'(watchdog_count);
               aao_pkg::PRECLR_OFFSET:
                  prdata <= {30'h0, preclear_second,
                             preclear_first};
               default:
                  prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// [verilog/aao_pkg.sv]
/*
 Shared constants for the accumulator ALU datapath: operation codes,
 register offsets, status bit positions and reset values.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package aao_pkg;

   // Operation codes presented by the instruction decoder
   typedef enum logic [4:0] {
      OP_NOP        = 5'h00,
      OP_ADC_ACC    = 5'h01,
      OP_ADC_MEM    = 5'h02,
      OP_ADD_ACC    = 5'h03,
      OP_ADD_IMM    = 5'h04,
      OP_ADD_MEM    = 5'h05,
      OP_AND_ACC    = 5'h06,
      OP_AND_IMM    = 5'h07,
      OP_AND_MEM    = 5'h08,
      OP_CALL       = 5'h09,
      OP_CLEAR_BYTE = 5'h0A,
      OP_CLEAR_BIT  = 5'h0B,
      OP_WDT_SINGLE = 5'h0C,
      OP_WDT_FIRST  = 5'h0D,
      OP_WDT_SECOND = 5'h0E,
      OP_INVERT_MEM = 5'h0F,
      OP_INVERT_ACC = 5'h10,
      OP_DEC_ADJUST = 5'h11,
      OP_DEC_MEM    = 5'h12,
      OP_DEC_ACC    = 5'h13
   } aao_op_type;

   // APB register byte offsets
   localparam logic [7:0] ACC_OFFSET    = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] WDT_OFFSET    = 8'h08;
   localparam logic [7:0] PRECLR_OFFSET = 8'h0C;

   // Status register bit positions
   localparam int C_BIT   = 0;
   localparam int AC_BIT  = 1;
   localparam int Z_BIT   = 2;
   localparam int OV_BIT  = 3;
   localparam int PDF_BIT = 4;
   localparam int TO_BIT  = 5;

   // Reset values
   localparam logic [7:0] ACC_RESET  = 8'h00;
   localparam logic       FLAG_RESET = 1'b0;

   // Decimal adjust constants
   localparam logic [4:0] BCD_LIMIT  = 5'h09;
   localparam logic [4:0] BCD_ADJUST = 5'h06;

endpackage

// [test/aao_chk.sv]
/*
 Concurrent checks on the datapath's ports: call, byte clear, invert,
 decrement, AND zero flag, watchdog clear and APB answer timing.
 Assumes one clock, pclk, and the asynchronous active-low presetn.
*/
`timescale 1ns/1ns
module aao_chk #(
   parameter int WDT_WIDTH = 8,
   parameter int PC_WIDTH  = 12
) (
   // Clock and reset
   input wire logic                 pclk,
   input wire logic                 presetn,
   // APB handshake
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pready,
   // Operation request
   input wire logic                 op_valid,
   input wire logic [4:0]           op_code,
   input wire logic [7:0]           mem_rdata,
   input wire logic [PC_WIDTH-1:0]  pc_now,
   input wire logic [PC_WIDTH-1:0]  call_target,
   // Results
   input wire logic                 mem_we,
   input wire logic [7:0]           mem_wdata,
   input wire logic                 stack_push,
   input wire logic                 pc_load,
   input wire logic [PC_WIDTH-1:0]  stack_data,
   input wire logic [PC_WIDTH-1:0]  pc_target,
   input wire logic [7:0]           accumulator_reg,
   input wire logic                 zero_flag,
   input wire logic [WDT_WIDTH-1:0] watchdog_count
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence is_op(logic [4:0] c);
      op_valid && op_code == c;
   endsequence

   chk_call_push: assert property (is_op(aao_pkg::OP_CALL) |=>
      stack_push && pc_load && stack_data == $past(pc_now) + 1'b1
      && pc_target == $past(call_target))
      else $error("call did not push next address and load target");
   chk_push_pulse: assert property (stack_push == pc_load
      && stack_push == $past(op_valid && op_code == aao_pkg::OP_CALL))
      else $error("stack push not a single pulse with pc load");
   chk_clear_byte: assert property (is_op(aao_pkg::OP_CLEAR_BYTE) |=>
      mem_we && mem_wdata == 8'h00)
      else $error("byte clear did not write zero");
   chk_dec_mem: assert property (is_op(aao_pkg::OP_DEC_MEM) |=>
      mem_we && mem_wdata == $past(mem_rdata) - 8'h01)
      else $error("decrement wrote wrong byte");
   chk_invert_acc: assert property (is_op(aao_pkg::OP_INVERT_ACC) |=>
      accumulator_reg == ~$past(mem_rdata) && !mem_we)
      else $error("invert to accumulator wrong");
   chk_and_zero: assert property (is_op(aao_pkg::OP_AND_ACC) |=>
      zero_flag == (accumulator_reg == 8'h00))
      else $error("zero flag disagrees with AND result");
   chk_wdt_clear: assert property (is_op(aao_pkg::OP_WDT_SINGLE) |=>
      watchdog_count == '0)
      else $error("watchdog count not cleared");
   chk_apb_answer: assert property (psel && penable && !pready |=> pready)
      else $error("APB access not answered in one cycle");
   chk_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");

   cover property (is_op(aao_pkg::OP_CALL));
   cover property (is_op(aao_pkg::OP_WDT_FIRST));
   cover property (is_op(aao_pkg::OP_DEC_ADJUST));
   cover property (psel && penable && pready);
endmodule

bind aao_top aao_chk #(.WDT_WIDTH(WDT_WIDTH), .PC_WIDTH(PC_WIDTH)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .op_valid(op_valid), .op_code(op_code),
   .mem_rdata(mem_rdata), .pc_now(pc_now), .call_target(call_target),
   .mem_we(mem_we), .mem_wdata(mem_wdata), .stack_push(stack_push),
   .pc_load(pc_load), .stack_data(stack_data), .pc_target(pc_target),
   .accumulator_reg(accumulator_reg), .zero_flag(zero_flag),
   .watchdog_count(watchdog_count));

// [test/aao_mem_model.sv]
/*
 Data memory at the far side: read follows the address at once.
 Assumes mem_we, mem_waddr and mem_wdata are registered on pclk.
*/
`timescale 1ns/1ns
module aao_mem_model (
   // Clock
   input  wire logic       pclk,
   // Memory port
   input  wire logic [7:0] mem_addr,
   output logic      [7:0] mem_rdata,
   input  wire logic       mem_we,
   input  wire logic [7:0] mem_waddr,
   input  wire logic [7:0] mem_wdata
);
   logic [7:0] store [256];
   assign mem_rdata = store[mem_addr];
   // Written on the edge ending the pulse, so one idle cycle between ops
   always @(posedge pclk) begin
      if (mem_we) begin
         store[mem_waddr] <= mem_wdata;
      end
   end
   task preload(input logic [7:0] a, input logic [7:0] v);
      store[a] = v;
   endtask
endmodule

// [test/test_accumulator_alu_ops.sv]
/*
 Self-checking bench for the datapath: APB registers, arithmetic, logic,
 clears, call, decimal adjust and watchdog clears.
 Assumes aao_top, aao_pkg and the memory model are compiled first.
*/
`timescale 1ns/1ns
module test_accumulator_alu_ops;
   logic        pclk, presetn, psel, penable, pwrite, op_valid, pd_set;
   logic        pready, pslverr, mem_we, stack_push, pc_load, err;
   logic        c_f, ac_f, z_f, ov_f, pd_f, to_f;
   logic [7:0]  paddr, mem_addr, mem_rdata, imm_data, mem_waddr, mem_wdata;
   logic [7:0]  acc, r;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0]  op_code, wdt, wdt0;
   logic [2:0]  bit_sel;
   logic [11:0] pc_now, call_target, stack_data, pc_target;
   int          mismatches, samples_checked;

   aao_top #(.WDT_WIDTH(5)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .op_valid(op_valid), .op_code(op_code), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel),
      .pc_now(pc_now), .call_target(call_target), .power_down_set(pd_set),
      .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
      .stack_push(stack_push), .stack_data(stack_data), .pc_load(pc_load),
      .pc_target(pc_target), .accumulator_reg(acc), .carry_flag(c_f),
      .aux_carry_flag(ac_f), .zero_flag(z_f), .overflow_flag(ov_f),
      .power_down_flag(pd_f), .timeout_flag(to_f), .watchdog_count(wdt));
   aao_mem_model mem (.pclk(pclk), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
      .mem_wdata(mem_wdata));

   always #4 pclk = ~pclk;

   task check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task results;
      if (mismatches == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (pready !== 1'b1) begin
         mismatches++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Leaves the bench in the cycle where the op's results stand
   task do_op(input logic [4:0] op, input logic [7:0] a, x,
              input logic [2:0] b);
      @(posedge pclk);
      op_valid <= 1'b1;
      op_code <= op;
      mem_addr <= a;
      imm_data <= x;
      bit_sel <= b;
      #1 wdt0 = wdt;
      @(posedge pclk);
      op_valid <= 1'b0;
      #1;
   endtask

   task preset(input logic [7:0] a, input logic [3:0] st);
      apb(1'b1, aao_pkg::ACC_OFFSET, {24'h0, a});
      apb(1'b1, aao_pkg::STATUS_OFFSET, {28'h0, st});
   endtask

   task t_regs;
      apb(1'b0, aao_pkg::ACC_OFFSET, 32'h0);
      check("acc reset", rd, 32'h0);
      apb(1'b1, aao_pkg::ACC_OFFSET, 32'hA5);
      apb(1'b0, aao_pkg::ACC_OFFSET, 32'h0);
      check("acc read", rd, 32'hA5);
      apb(1'b1, aao_pkg::WDT_OFFSET, 32'h0);
      check("ro write err", err, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped", {rd[30:0], err}, 32'h1);
   endtask

   task t_add;
      logic [4:0] op;
      logic [8:0] s;
      logic [7:0] a, m;
      logic       ci, ov, dst;
      for (int p = 0; p < 2; p++) begin
         a = p ? 8'hF0 : 8'h79;
         m = p ? 8'h10 : 8'h08;
         for (int i = 0; i < 5; i++) begin
            op = aao_pkg::OP_ADC_ACC + 5'(i);
            ci = (i < 2) && !p;
            dst = (i == 1 || i == 4);
            preset(a, {1'(p), 2'h0, !p});
            mem.preload(8'h20, m);
            do_op(op, 8'h20, m, 3'h0);
            s = a + m + ci;
            ov = (i == 0) ? 1'(p) : (a[7] == m[7] && s[7] != a[7]);
            check("sum", dst ? mem_wdata : acc, s[7:0]);
            check("sum we", {mem_we, mem_waddr}, {dst, 8'h20});
            check("add flags", {ov_f, z_f, ac_f, c_f}, {ov, s[7:0] == 0,
               (a[3:0] + m[3:0] + ci) > 5'hF, s[8]});
         end
      end
   endtask

   task t_logic;
      logic [4:0] op;
      logic [7:0] m;
      logic       dst;
      for (int k = 0; k < 3; k++) begin
         m = (k == 0) ? 8'hC3 : (k == 1) ? 8'h01 : 8'hFF;
         for (int i = 0; i < 7; i++) begin
            op = (i < 3) ? aao_pkg::OP_AND_ACC + 5'(i)
                         : aao_pkg::OP_INVERT_MEM + 5'(i - 2 - (i < 5));
            dst = (i == 2 || i == 3 || i == 5);
            r = (i < 3) ? 8'h3C & m : (i < 5) ? ~m : m - 8'h01;
            preset(8'h3C, 4'hB);
            mem.preload(8'h21, m);
            do_op(op, 8'h21, m, 3'h0);
            check("logic", dst ? mem_wdata : acc, r);
            check("logic we", mem_we, dst);
            check("logic flags", {ov_f, z_f, ac_f, c_f},
               {2'b10 | 2'(r == 0), 2'h3});
         end
      end
   endtask

   task t_clear;
      preset(8'h00, 4'hF);
      mem.preload(8'h22, 8'hFF);
      do_op(aao_pkg::OP_CLEAR_BYTE, 8'h22, 8'h00, 3'h0);
      check("clear byte", {mem_we, mem_wdata}, 9'h100);
      for (int b = 0; b < 8; b++) begin
         @(posedge pclk);
         #1 mem.preload(8'h22, 8'hFF);
         do_op(aao_pkg::OP_CLEAR_BIT, 8'h22, 8'h00, 3'(b));
         check("clear bit", mem_wdata, 8'(~(8'h01 << b)));
         check("clear flags", {ov_f, z_f, ac_f, c_f}, 4'hF);
      end
   endtask

   task t_call;
      @(posedge pclk);
      pc_now <= 12'h7FF;
      call_target <= 12'h123;
      do_op(aao_pkg::OP_CALL, 8'h00, 8'h00, 3'h0);
      check("call", {stack_push, pc_load, stack_data, pc_target},
         {2'h3, 12'h800, 12'h123});
      check("call flags", {ov_f, z_f, ac_f, c_f}, 4'hF);
   endtask

   task t_daa;
      logic [9:0] cs [4] = '{10'h268, 10'h116, 10'h04A, 10'h0E0};
      logic [4:0] lo, hi;
      logic       ac, c;
      for (int i = 0; i < 4; i++) begin
         {ac, c} = cs[i][1:0];
         preset(cs[i][9:2], {2'h3, ac, c});
         do_op(aao_pkg::OP_DEC_ADJUST, 8'h23, 8'h00, 3'h0);
         lo = {1'b0, cs[i][5:2]};
         if (lo > 5'h9 || ac)
            lo = lo + 5'h6;
         hi = {1'b0, cs[i][9:6]} + lo[4];
         if (hi > 5'h9 || c) begin
            hi = hi + 5'h6;
            c = 1'b1;
         end
         check("adjust", {mem_we, mem_wdata}, {1'b1, hi[3:0], lo[3:0]});
         check("adjust flags", {ov_f, z_f, ac_f, c_f}, {2'h3, ac, c});
      end
   endtask

   task pd_pulse;
      @(posedge pclk);
      pd_set <= 1'b1;
      @(posedge pclk);
      pd_set <= 1'b0;
   endtask

   // Keeps a wrap, which sets timeout, away from the clearing edge
   task settle;
      for (int n = 0; n < 64 && wdt >= 5'h4; n++)
         @(posedge pclk) #1;
      if (wdt >= 5'h4) begin
         mismatches++;
         results();
      end
   endtask

   task t_wdt;
      pd_pulse();
      for (int n = 0; n < 80 && to_f !== 1'b1; n++)
         @(posedge pclk) #1;
      if (to_f !== 1'b1) begin
         mismatches++;
         results();
      end
      do_op(aao_pkg::OP_WDT_SINGLE, 8'h00, 8'h00, 3'h0);
      check("single", {wdt, pd_f, to_f}, 7'h0);
      for (int o = 0; o < 2; o++) begin
         pd_pulse();
         settle();
         do_op(o ? aao_pkg::OP_WDT_SECOND : aao_pkg::OP_WDT_FIRST,
            8'h00, 8'h00, 3'h0);
         check("half", {wdt, pd_f}, {wdt0 + 5'h1, 1'b1});
         apb(1'b0, aao_pkg::PRECLR_OFFSET, 32'h0);
         check("half mark", rd, o ? 32'h2 : 32'h1);
         settle();
         do_op(o ? aao_pkg::OP_WDT_FIRST : aao_pkg::OP_WDT_SECOND,
            8'h00, 8'h00, 3'h0);
         check("pair", {wdt, pd_f, to_f}, 7'h0);
      end
   endtask

   initial begin
      {pclk, presetn, psel, penable, pwrite, op_valid, pd_set} = '0;
      {paddr, pwdata, op_code, mem_addr, imm_data, bit_sel} = '0;
      {pc_now, call_target, mismatches, samples_checked} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_add();
      t_logic();
      t_clear();
      t_call();
      t_daa();
      t_wdt();
      results();
   end
endmodule
